// ### inc/codec_pwr_pkg.sv
package codec_pwr_pkg;
  localparam int CLK_MHZ = 25;
  // Requested and reported power state codes
  localparam logic [3:0] PS_D0 = 4'h0;
  localparam logic [3:0] PS_D1 = 4'h1;
  localparam logic [3:0] PS_D2 = 4'h2;
  localparam logic [3:0] PS_D3 = 4'h3;
  localparam logic [3:0] PS_D3COLD = 4'h4;
  typedef enum logic [2:0] {
    st_d0 = 3'b000,
    st_d1 = 3'b001,
    st_d2 = 3'b010,
    st_d3 = 3'b011,
    st_d3cold = 3'b100,
    st_deep = 3'b101,
    st_deepest = 3'b110
  } afg_t;
  localparam logic [11:0] VERB_SET_PS = 12'h705;
  localparam logic [11:0] VERB_GET_PS = 12'hf05;
  localparam logic [11:0] VERB_SET_VPWR = 12'h7f0;
  localparam logic [11:0] VERB_GET_VPWR = 12'hff0;
  localparam logic [11:0] VERB_FG_RESET = 12'h7ff;
  // Vendor power control byte layout
  localparam int VP_SEL_LSB = 0;
  localparam int VP_MIX_DIS = 2;
  localparam int VP_AMP_DIS = 3;
  localparam int VP_SENSE_DIS = 4;
  localparam int VP_REF_DIS = 5;
  localparam logic [1:0] VP_SEL_DEEP = 2'h1;
  localparam logic [1:0] VP_SEL_DEEPEST = 2'h2;
  localparam logic [7:0] VPWR_RST = 8'h00;
  localparam logic [3:0] AFG_PS_RST = 4'h3;
  localparam logic [3:0] NODE_PS_RST = 4'h0;
  // Node index 0 is the function group, then converters, then pins
  localparam int NUM_CNV = 8;
  localparam int NUM_PIN = 8;
  localparam int NUM_NODES = 1 + NUM_CNV + NUM_PIN;
  localparam logic [4:0] NODE_LIMIT = 5'h11;
  localparam int PS_ACT_LSB = 4;
  localparam int PS_SET_LSB = 0;
  localparam int TMR_W = 23;
  localparam int T_D1_RESUME_US = 1000;
  localparam int T_D2_RESUME_US = 2000;
  localparam int T_D3_RESUME_US = 10000;
  localparam int T_COLD_RESUME_US = 200000;
  localparam logic [TMR_W-1:0] RES_D1_CYC_D = TMR_W'(T_D1_RESUME_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] RES_D2_CYC_D = TMR_W'(T_D2_RESUME_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] RES_D3_CYC_D = TMR_W'(T_D3_RESUME_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] RES_COLD_CYC_D = TMR_W'(T_COLD_RESUME_US * CLK_MHZ);
  // Bit clock counted as stopped after this many cycles without an edge
  localparam logic [4:0] BCLK_TIMEOUT = 5'h10;
  localparam int SYNC_W = 14;
endpackage

// ### hdl/settle_timer.sv
`timescale 1ns/1ns
module settle_timer #(
  parameter int W = 23
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_ff;
  logic done_ff;
  wire last = (cnt_ff == W'(1));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= last;
      if (start && cnt_ff == '0) begin
        cnt_ff <= load;
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - W'(1);
      end
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = done_ff;
endmodule // settle_timer

// ### hdl/codec_power_state_control.sv
`timescale 1ns/1ns
// How it works
// RULE1 - Power state set and get verbs work at function group, converters and pins.
// RULE2 - Converters run only while the effective state is D0.
// RULE3 - D1 stops DAC and ADC streams but keeps mixing and loop-through.
// RULE4 - In D0 a function runs only if its own node state is D0; the code also keeps pins on whose node state is D1.
// RULE5 - After reset the function group sits in D3.
// RULE6 - Return from D1 to D0 completes within one millisecond.
// RULE7 - D2 drops mixer and ports, keeps amps and references, resumes within 2 ms.
// RULE8 - D3 shuts all converters and resumes to D0 within ten milliseconds.
// RULE9 - PLL stays on in D3 with keep-alive, else stops in D3 and D3cold.
// RULE10 - PLL stops only after DAC fade-out and modulator settling.
// RULE11 - Stopped bit clock makes link logic inactive but wake still works.
// RULE12 - D3 sense change: unsolicited response, or wake first if link stopped.
// RULE13 - D3cold honours only double group reset and link reset; the code also accepts the vendor power set and get verbs at the function group.
// RULE14 - D3cold disables audio and presence detect but still answers resume requests.
// RULE15 - Two back-to-back group resets leave D3cold within 200 ms.
// RULE16 - Vendor deep states entered only after D3cold is requested.
// RULE17 - Vendor verb on function group combines power bits into two deep states.
// RULE18 - First vendor deep state stops answering on the link.
// RULE19 - Second deep state also turns off GPIO drivers and analog circuits.
// RULE20 - Vendor bits separately disable mixer, amps, presence detect and references.
// RULE21 - Deep states are left only by link reset or loss of supply.
// RULE22 - Software should request D3cold before selecting a deep state.
// RULE23 - Effective state is the lower-power of group and node; get reports both.
module codec_power_state_control
  import codec_pwr_pkg::*;
#(
  parameter logic [TMR_W-1:0] RES_D1_CYC = RES_D1_CYC_D,
  parameter logic [TMR_W-1:0] RES_D2_CYC = RES_D2_CYC_D,
  parameter logic [TMR_W-1:0] RES_D3_CYC = RES_D3_CYC_D,
  parameter logic [TMR_W-1:0] RES_COLD_CYC = RES_COLD_CYC_D
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic bit_clk_pin,
  input wire logic link_rst_n_pin,
  input wire logic [7:0] sense_pin,
  input wire logic [3:0] gpio_pin,
  input wire logic verb_valid,
  input wire logic [4:0] verb_node,
  input wire logic [11:0] verb_id,
  input wire logic [7:0] verb_payload,
  input wire logic spdif_keep_alive,
  input wire logic dac_fade_done,
  input wire logic sdm_settled,
  output logic resp_valid,
  output logic [31:0] resp_data,
  output logic [2:0] afg_state,
  output logic [NUM_CNV-1:0] cnv_run,
  output logic [NUM_PIN-1:0] pin_on,
  output logic mixer_en,
  output logic amp_en,
  output logic amp_low_drive,
  output logic ref_en,
  output logic port_sense_en,
  output logic link_resp_en,
  output logic gpio_drv_en,
  output logic analog_en,
  output logic pll_en,
  output logic dac_fade_req,
  output logic wake_req,
  output logic unsol_req
);
  logic [SYNC_W-1:0] sync1_ff, sync2_ff, sync3_ff;
  logic [4:0] bclk_cnt_ff;
  logic [3:0] node_ps_ff [NUM_NODES];
  logic [7:0] vpwr_ff;
  afg_t afg_ff, nxt_afg, tgt, step;
  logic pll_ff, pend_ff, fgr_seen_ff, resp_valid_ff;
  logic [31:0] resp_data_ff;
  logic [TMR_W-1:0] res_load, wait_cnt_ff;
  logic tmr_busy, tmr_done;

  // Pins cross in through two flops; sync3 only holds the previous sample
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= {link_rst_n_pin, bit_clk_pin, gpio_pin, sense_pin};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  wire link_rst_n_s = sync2_ff[13];
  wire bclk_edge = sync2_ff[12] ^ sync3_ff[12];
  wire [3:0] gpio_chg = sync2_ff[11:8] ^ sync3_ff[11:8];
  wire [7:0] sense_chg = sync2_ff[7:0] ^ sync3_ff[7:0];

  // A stopped bit clock shows up as no edge for a timeout window
  always_ff @(posedge clk_sys) begin
    if (rst || bclk_edge) begin
      bclk_cnt_ff <= '0;
    end else if (bclk_cnt_ff != BCLK_TIMEOUT) begin
      bclk_cnt_ff <= bclk_cnt_ff + 5'h01;
    end
  end

  wire bclk_run = (bclk_cnt_ff != BCLK_TIMEOUT);
  wire link_up = bclk_run && link_rst_n_s; // [RULE11]

  wire [3:0] afg_set = node_ps_ff[0];
  wire [1:0] deep_sel = vpwr_ff[VP_SEL_LSB +: 2];
  wire [3:0] afg_ps = (afg_ff >= st_d3cold) ? PS_D3COLD : {1'b0, afg_ff};
  wire in_deep = (afg_ff == st_deep) || (afg_ff == st_deepest);

  // Deep variants only exist as flavours of a requested D3cold
  assign tgt = (afg_set != PS_D3COLD) ? afg_t'(afg_set[2:0]) :
               (deep_sel == VP_SEL_DEEP) ? st_deep :
               (deep_sel == VP_SEL_DEEPEST) ? st_deepest : st_d3cold; // [RULE16] [RULE17]
  assign step = ((tgt == st_deep || tgt == st_deepest) && afg_ff != st_d3cold) ?
                st_d3cold : tgt; // [RULE16]
  wire deeper = (tgt > afg_ff);
  wire shallower = (tgt < afg_ff);

  // Verb acceptance: D3cold keeps a narrow door open, deep states none
  wire is_fgr = (verb_id == VERB_FG_RESET);
  wire is_vpwr = (verb_id == VERB_SET_VPWR) || (verb_id == VERB_GET_VPWR);
  wire cold_ok = is_fgr || (is_vpwr && verb_node == 5'h00);
  wire acc = verb_valid && link_up && (verb_node < NODE_LIMIT) &&
             ((afg_ff <= st_d3) || (afg_ff == st_d3cold && cold_ok)); // [RULE13] [RULE18]
  wire set_ps = acc && verb_id == VERB_SET_PS && afg_ff <= st_d3; // [RULE1]
  wire ps_ok = (verb_node == 5'h00) ? (verb_payload[3:0] <= PS_D3COLD) :
               (verb_payload[3:0] <= PS_D3);
  wire set_vpwr = acc && verb_id == VERB_SET_VPWR && verb_node == 5'h00; // [RULE17]
  wire fgr_single = acc && is_fgr && afg_ff <= st_d3;
  wire fgr_double = acc && is_fgr && afg_ff == st_d3cold && fgr_seen_ff; // [RULE15]
  wire group_reset = !link_rst_n_s || fgr_single;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fgr_seen_ff <= 1'b0;
    end else if (acc) begin
      fgr_seen_ff <= is_fgr && !fgr_double;
    end
  end

  // Requested states: index 0 is the function group
  always_ff @(posedge clk_sys) begin
    if (rst || group_reset) begin
      node_ps_ff[0] <= AFG_PS_RST; // [RULE5] [RULE21]
      for (int i = 1; i < NUM_NODES; i++) begin
        node_ps_ff[i] <= NODE_PS_RST;
      end
    end else if (fgr_double) begin
      node_ps_ff[0] <= PS_D3; // [RULE15]
    end else if (set_ps && ps_ok) begin
      node_ps_ff[verb_node] <= verb_payload[3:0]; // [RULE1]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || group_reset) begin
      vpwr_ff <= VPWR_RST;
    end else if (set_vpwr) begin
      vpwr_ff <= verb_payload; // [RULE20]
    end
  end

  // Going deeper is immediate; coming up waits the resume time of the state left
  wire [TMR_W-1:0] res_cyc = (afg_ff == st_d1) ? RES_D1_CYC :
                             (afg_ff == st_d2) ? RES_D2_CYC :
                             (afg_ff == st_d3) ? RES_D3_CYC : RES_COLD_CYC;
  // Request and timer load take two cycles; count them so resume meets its limit
  assign res_load = res_cyc - TMR_W'(2); // [RULE6] [RULE7] [RULE8] [RULE15]
  wire tmr_start = shallower && !tmr_busy && !tmr_done;

  settle_timer #(
    .W(TMR_W)
  ) u_resume (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(tmr_start),
    .load(res_load),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // Link reset can coincide with a pending move, so it must outrank it
  always_comb begin
    nxt_afg = afg_ff;
    if (!link_rst_n_s) begin
      nxt_afg = st_d3; // [RULE21]
    end else if (deeper) begin
      nxt_afg = step;
    end else if (shallower && tmr_done) begin
      nxt_afg = tgt; // [RULE15]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      afg_ff <= st_d3; // [RULE5]
    end else begin
      afg_ff <= nxt_afg;
    end
  end

  // PLL runs through D2, in D3 only for keep-alive; stopping waits for fade
  wire pll_need = (afg_ff <= st_d2) || (afg_ff == st_d3 && spdif_keep_alive); // [RULE9]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pll_ff <= 1'b0;
    end else if (pll_need) begin
      pll_ff <= 1'b1;
    end else if (dac_fade_done && sdm_settled) begin
      pll_ff <= 1'b0; // [RULE10]
    end
  end

  // Functional enables
  generate
    for (genvar g = 0; g < NUM_CNV; g++) begin : g_cnv
      assign cnv_run[g] = (afg_ff == st_d0) && (node_ps_ff[1 + g] == PS_D0); // [RULE2] [RULE3] [RULE4]
    end
    for (genvar g = 0; g < NUM_PIN; g++) begin : g_pin
      // Port function lives in D0 and D1 only
      assign pin_on[g] = (afg_ff <= st_d1) && (node_ps_ff[1 + NUM_CNV + g] <= PS_D1); // [RULE7] [RULE23]
    end
  endgenerate

  assign mixer_en = (afg_ff <= st_d1) && !vpwr_ff[VP_MIX_DIS]; // [RULE3] [RULE7] [RULE20]
  assign amp_en = (afg_ff <= st_d2) && !vpwr_ff[VP_AMP_DIS]; // [RULE7] [RULE20]
  assign amp_low_drive = (afg_ff >= st_d3) && (afg_ff != st_deepest) && !vpwr_ff[VP_AMP_DIS];
  assign ref_en = (afg_ff != st_deepest) && !vpwr_ff[VP_REF_DIS]; // [RULE19] [RULE20]
  assign port_sense_en = (afg_ff <= st_d3) && !vpwr_ff[VP_SENSE_DIS]; // [RULE14] [RULE20]
  assign link_resp_en = link_up && (afg_ff <= st_d3cold); // [RULE11] [RULE18]
  assign gpio_drv_en = (afg_ff != st_deepest); // [RULE19]
  assign analog_en = (afg_ff != st_deepest); // [RULE19]
  assign pll_en = pll_ff;
  assign dac_fade_req = pll_ff && !pll_need;
  assign afg_state = afg_ff;

  // Sense and GPIO events; a new event beats the clear of the same cycle
  wire evt = ((|sense_chg) && port_sense_en) || ((|gpio_chg) && afg_ff <= st_d3);
  assign unsol_req = pend_ff && link_up; // [RULE12]
  assign wake_req = pend_ff && !link_up && (afg_ff == st_d3); // [RULE11] [RULE12]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= evt || (pend_ff && !unsol_req); // [RULE12]
    end
  end

  // Get answers: active state in the high nibble, requested in the low
  wire [3:0] node_set = node_ps_ff[verb_node];
  wire [3:0] node_eff = (node_set > afg_ps) ? node_set : afg_ps;
  wire [3:0] act_ps = (verb_node == 5'h00) ? afg_ps : node_eff; // [RULE23]
  wire [31:0] get_word = (32'(act_ps) << PS_ACT_LSB) | (32'(node_set) << PS_SET_LSB);
  wire [31:0] rsp_word = (verb_id == VERB_GET_PS) ? get_word :
                         (verb_id == VERB_GET_VPWR) ? {24'h000000, vpwr_ff} : 32'h00000000;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp_valid_ff <= 1'b0;
      resp_data_ff <= '0;
    end else begin
      resp_valid_ff <= acc; // [RULE1] [RULE14]
      if (acc) begin
        resp_data_ff <= rsp_word;
      end
    end
  end

  assign resp_valid = resp_valid_ff;
  assign resp_data = resp_data_ff;

  // Helper: cycles spent waiting to come up
  always_ff @(posedge clk_sys) begin
    if (rst || !shallower) begin
      wait_cnt_ff <= '0;
    end else begin
      wait_cnt_ff <= wait_cnt_ff + TMR_W'(1);
    end
  end

  property p_cnv_d0;
    @(posedge clk_sys) disable iff (rst) (|cnv_run) |-> afg_ff == st_d0;
  endproperty
  a_cnv_d0: assert property (p_cnv_d0) else $error("converter runs outside D0"); // [RULE2]

  property p_reset_d3;
    @(posedge clk_sys) $past(rst) && !rst |-> afg_ff == st_d3 && node_ps_ff[0] == PS_D3;
  endproperty
  a_reset_d3: assert property (p_reset_d3) else $error("not D3 after reset"); // [RULE5]

  property p_resume_d1;
    @(posedge clk_sys) disable iff (rst) afg_ff == st_d1 |-> wait_cnt_ff < RES_D1_CYC;
  endproperty
  a_resume_d1: assert property (p_resume_d1) else $error("D1 resume too slow"); // [RULE6]

  property p_keep_alive;
    @(posedge clk_sys) disable iff (rst)
      pll_ff && afg_ff == st_d3 && spdif_keep_alive |=> pll_ff;
  endproperty
  a_keep_alive: assert property (p_keep_alive) else $error("PLL stopped with keep-alive"); // [RULE9]

  property p_pll_fade;
    @(posedge clk_sys) disable iff (rst) $fell(pll_ff) |-> $past(dac_fade_done && sdm_settled);
  endproperty
  a_pll_fade: assert property (p_pll_fade) else $error("PLL stopped before fade done"); // [RULE10]

  property p_cold_ignore;
    @(posedge clk_sys) disable iff (rst)
      verb_valid && afg_ff == st_d3cold && verb_id == VERB_GET_PS |=> !resp_valid;
  endproperty
  a_cold_ignore: assert property (p_cold_ignore) else $error("D3cold answered a verb"); // [RULE13]

  property p_deep_entry;
    @(posedge clk_sys) disable iff (rst)
      in_deep && !$past(in_deep) |-> $past(afg_ff) == st_d3cold;
  endproperty
  a_deep_entry: assert property (p_deep_entry) else $error("deep state not via D3cold"); // [RULE16]

  property p_deep_silent;
    @(posedge clk_sys) disable iff (rst) in_deep ##1 verb_valid |=> !resp_valid;
  endproperty
  a_deep_silent: assert property (p_deep_silent) else $error("deep state answered"); // [RULE18]

  property p_deepest_off;
    @(posedge clk_sys) disable iff (rst) afg_ff == st_deepest |-> !gpio_drv_en && !analog_en;
  endproperty
  a_deepest_off: assert property (p_deepest_off) else $error("deepest state left drivers on"); // [RULE19]

  property p_pend_hold;
    @(posedge clk_sys) disable iff (rst) pend_ff && !link_up |=> pend_ff;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending event lost"); // [RULE12]

  c_d3_to_d0: cover property (@(posedge clk_sys) disable iff (rst)
    afg_ff == st_d3 ##1 afg_ff == st_d0);
  c_deep: cover property (@(posedge clk_sys) disable iff (rst) $rose(in_deep));
  c_fade: cover property (@(posedge clk_sys) disable iff (rst) $fell(pll_ff));
  c_wake: cover property (@(posedge clk_sys) disable iff (rst) wake_req ##[1:200] unsol_req);
endmodule // codec_power_state_control

// ### testbench/link_ctl_model.sv
`timescale 1ns/1ns
module link_ctl_model (
  input wire logic link_on,
  output logic bit_clk_pin,
  output logic link_rst_n_pin
);
  // Bit clock stands low while the link is held in reset
  initial begin
    bit_clk_pin = 1'b0;
    #13;
    forever begin
      #160;
      bit_clk_pin = link_on ? ~bit_clk_pin : 1'b0;
    end
  end
  // Recovery from any deep state is by this reset only
  assign link_rst_n_pin = link_on;
endmodule // link_ctl_model

// ### testbench/codec_power_state_control_tb.sv
`timescale 1ns/1ns
module codec_power_state_control_tb;
  import codec_pwr_pkg::*;
  logic clk_sys, rst, link_on, bit_clk_pin, link_rst_n_pin, verb_valid;
  logic [7:0] sense_pin, verb_payload, pin_on, cnv_run;
  logic [3:0] gpio_pin;
  logic [4:0] verb_node;
  logic [11:0] verb_id;
  logic spdif_keep_alive, dac_fade_done, sdm_settled, resp_valid;
  logic [31:0] resp_data, rd;
  logic [2:0] afg_state;
  logic mixer_en, amp_en, amp_low_drive, ref_en, port_sense_en, link_resp_en;
  logic gpio_drv_en, analog_en, pll_en, dac_fade_req, wake_req, unsol_req, rv;
  int bad_count, tests_run;
  int unsol_cnt, unsol_base;
  codec_power_state_control #(.RES_D1_CYC(23'h14), .RES_D2_CYC(23'h28),
    .RES_D3_CYC(23'h50), .RES_COLD_CYC(23'ha0)) codec_power_state_control_i (.clk_sys(clk_sys),
    .rst(rst), .bit_clk_pin(bit_clk_pin), .link_rst_n_pin(link_rst_n_pin),
    .sense_pin(sense_pin), .gpio_pin(gpio_pin), .verb_valid(verb_valid),
    .verb_node(verb_node), .verb_id(verb_id), .verb_payload(verb_payload),
    .spdif_keep_alive(spdif_keep_alive), .dac_fade_done(dac_fade_done),
    .sdm_settled(sdm_settled), .resp_valid(resp_valid), .resp_data(resp_data),
    .afg_state(afg_state), .cnv_run(cnv_run), .pin_on(pin_on), .mixer_en(mixer_en),
    .amp_en(amp_en), .amp_low_drive(amp_low_drive), .ref_en(ref_en),
    .port_sense_en(port_sense_en), .link_resp_en(link_resp_en), .gpio_drv_en(gpio_drv_en),
    .analog_en(analog_en), .pll_en(pll_en), .dac_fade_req(dac_fade_req),
    .wake_req(wake_req), .unsol_req(unsol_req));
  link_ctl_model link_ctl_model_i (.link_on(link_on), .bit_clk_pin(bit_clk_pin),
    .link_rst_n_pin(link_rst_n_pin));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Counts unsolicited responses, each pulse lasts one cycle only
  always @(posedge clk_sys) begin
    if (rst) begin
      unsol_cnt <= 0;
    end else if (unsol_req === 1'b1) begin
      unsol_cnt <= unsol_cnt + 1;
    end
  end
  task automatic wrap_up;
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic verb(input logic [4:0] n, input logic [11:0] id, input logic [7:0] pl);
    verb_valid = 1'b1;
    verb_node = n;
    verb_id = id;
    verb_payload = pl;
    tick(1);
    verb_valid = 1'b0;
    rv = resp_valid;
    rd = resp_data;
    tick(1);
  endtask
  task automatic wait_state(input logic [2:0] s, input int lim);
    int k;
    k = 0;
    while (afg_state !== s && k < lim) begin
      tick(1);
      k++;
    end
    chk("afg_state", {29'h0, s}, {29'h0, afg_state});
    if (afg_state !== s) wrap_up();
  endtask
  task automatic link_cycle;
    link_on = 1'b0;
    tick(40);
    link_on = 1'b1;
    tick(40);
  endtask
  initial begin
    bad_count = 0;
    tests_run = 0;
    rst = 1'b1;
    link_on = 1'b0;
    verb_valid = 1'b0;
    verb_node = 5'h00;
    verb_id = 12'h000;
    verb_payload = 8'h00;
    sense_pin = 8'h00;
    gpio_pin = 4'h0;
    spdif_keep_alive = 1'b0;
    dac_fade_done = 1'b0;
    sdm_settled = 1'b0;
    tick(2);
    rst = 1'b0;
    link_on = 1'b1;
    tick(30);
    chk("afg_state", 32'h3, {29'h0, afg_state});
    chk("pll_en", 32'h0, {31'h0, pll_en});
    chk("cnv_run", 32'h0, {24'h0, cnv_run});
    for (int n = 0; n < 18; n++) begin
      verb(n[4:0], VERB_GET_PS, 8'h00);
      chk("get_ps_resp", (n < 17) ? 32'h1 : 32'h0, {31'h0, rv});
      if (n < 17) chk("get_ps", (n == 0) ? 32'h33 : 32'h30, {24'h0, rd[7:0]});
    end
    verb(5'h00, VERB_SET_PS, 8'h00);
    wait_state(3'h0, 79);
    chk("cnv_run", 32'hff, {24'h0, cnv_run});
    for (int i = 2; i < 6; i++) begin
      verb(5'h00, VERB_SET_VPWR, 8'h01 << i);
      chk("vendor_dis", 32'hf ^ (32'h1 << (i - 2)),
        {28'h0, ref_en, port_sense_en, amp_en, mixer_en});
      verb(5'h00, VERB_GET_VPWR, 8'h00);
      chk("get_vpwr", 32'h1 << i, {24'h0, rd[7:0]});
    end
    verb(5'h00, VERB_SET_VPWR, 8'h00);
    verb(5'h01, VERB_SET_PS, 8'h03);
    chk("cnv_run", 32'hfe, {24'h0, cnv_run});
    verb(5'h01, VERB_GET_PS, 8'h00);
    chk("get_ps", 32'h33, {24'h0, rd[7:0]});
    verb(5'h01, VERB_SET_PS, 8'h00);
    verb(5'h00, VERB_SET_PS, 8'h01);
    wait_state(3'h1, 4);
    chk("d1_cnv", 32'h0, {24'h0, cnv_run});
    chk("d1_mix", 32'h1, {31'h0, mixer_en});
    chk("d1_pins", 32'hff, {24'h0, pin_on});
    verb(5'h00, VERB_SET_PS, 8'h00);
    wait_state(3'h0, 19);
    verb(5'h00, VERB_SET_PS, 8'h02);
    wait_state(3'h2, 4);
    chk("d2_en", 32'h3, {27'h0, amp_low_drive, mixer_en, |pin_on, amp_en, ref_en});
    verb(5'h00, VERB_SET_PS, 8'h00);
    wait_state(3'h0, 39);
    verb(5'h00, VERB_SET_PS, 8'h03);
    wait_state(3'h3, 4);
    chk("d3_amps", 32'h1, {31'h0, amp_low_drive});
    tick(5);
    chk("pll_fade", 32'h3, {30'h0, pll_en, dac_fade_req});
    dac_fade_done = 1'b1;
    tick(3);
    chk("pll_sdm", 32'h1, {31'h0, pll_en});
    sdm_settled = 1'b1;
    tick(3);
    chk("pll_off", 32'h0, {31'h0, pll_en});
    spdif_keep_alive = 1'b1;
    tick(3);
    chk("pll_keep", 32'h1, {31'h0, pll_en});
    spdif_keep_alive = 1'b0;
    unsol_base = unsol_cnt;
    sense_pin = 8'h01;
    tick(10);
    chk("unsol_up", 32'h2, {30'h0, unsol_cnt == unsol_base + 1, wake_req});
    link_on = 1'b0;
    tick(40);
    chk("link_down", 32'h0, {31'h0, link_resp_en});
    unsol_base = unsol_cnt;
    gpio_pin = 4'h1;
    tick(10);
    chk("wake", 32'h3, {30'h0, unsol_cnt == unsol_base, wake_req});
    link_on = 1'b1;
    tick(40);
    chk("unsol_after", 32'h2, {30'h0, unsol_cnt == unsol_base + 1, wake_req});
    verb(5'h00, VERB_SET_PS, 8'h04);
    wait_state(3'h4, 4);
    chk("cold_sense", 32'h0, {31'h0, port_sense_en});
    verb(5'h00, VERB_GET_PS, 8'h00);
    chk("cold_get", 32'h0, {31'h0, rv});
    verb(5'h00, VERB_FG_RESET, 8'h00);
    verb(5'h00, VERB_FG_RESET, 8'h00);
    chk("cold_rst", 32'h1, {31'h0, rv});
    wait_state(3'h3, 159);
    verb(5'h00, VERB_SET_VPWR, 8'h02);
    tick(5);
    chk("pre_sel", 32'h3, {29'h0, afg_state});
    verb(5'h00, VERB_SET_PS, 8'h04);
    wait_state(3'h6, 6);
    chk("deepest", 32'h0, {29'h0, gpio_drv_en, analog_en, link_resp_en});
    verb(5'h00, VERB_SET_PS, 8'h00);
    chk("deep_quiet", 32'h0, {31'h0, rv});
    link_cycle();
    chk("deep_exit", 32'h3, {29'h0, afg_state});
    verb(5'h00, VERB_SET_PS, 8'h04);
    wait_state(3'h4, 4);
    verb(5'h00, VERB_SET_VPWR, 8'h01);
    wait_state(3'h5, 6);
    verb(5'h00, VERB_GET_PS, 8'h00);
    chk("deep_get", 32'h0, {31'h0, rv});
    chk("deep_en", 32'h2, {30'h0, gpio_drv_en, link_resp_en});
    link_cycle();
    chk("deep_exit", 32'h3, {29'h0, afg_state});
    wrap_up();
  end
endmodule // codec_power_state_control_tb
